// *** shared/sbn_defs.svh ***
`ifndef SBN_DEFS_SVH
`define SBN_DEFS_SVH

// Identifiers
`define SBN_SYNC_ID_DEF 11'h080
`define SBN_EMCY_ID_BASE 11'h080
`define SBN_BOOT_ID_BASE 11'h700
`define SBN_NMT_ID 11'h000
// NMT command codes
`define SBN_CS_START 8'h01
`define SBN_CS_STOP 8'h02
`define SBN_CS_PREOP 8'h80
`define SBN_CS_RST_NODE 8'h81
`define SBN_CS_RST_COMM 8'h82
// Emergency reaction modes
`define SBN_REACT_FAULT 2'h0
`define SBN_REACT_WARN 2'h1
`define SBN_REACT_IGNORE 2'h2
// Status values
`define SBN_ERR_HI 8'h21
`define SBN_WARN_BIT 13
// Timing
`define SBN_CLK_HZ 125000000
`define SBN_TICK_MS 1
`define SBN_TICK_CYC (`SBN_CLK_HZ / 1000 * `SBN_TICK_MS)
// Reset values
`define SBN_RST_ERR 16'h0000

`endif

// *** shared/sbn_pkg.sv ***
package sbn_pkg;
    typedef enum logic [2:0]
    {
        SBN_ST_PREOP = 3'h1,
        SBN_ST_OPER = 3'h2,
        SBN_ST_STOP = 3'h4
    } sbn_nmt_e;

    typedef enum logic [3:0]
    {
        SBN_TX_IDLE = 4'h1,
        SBN_TX_BOOT = 4'h2,
        SBN_TX_EMCY = 4'h4,
        SBN_TX_SYNC = 4'h8
    } sbn_tx_e;
endpackage

// *** rtl/sbn_node.sv ***
// Contract
// - Master sends SYNC periodically when enabled
// - SYNC has no data, default ID 128
// - SYNC ID zero selects default identifier
// - SYNC period zero disables SYNC
// - Slave fault sends 8-byte emergency, 128+ID
// - Acknowledge sends all-zero emergency
// - Two-bit master emergency reaction select
// - Fault mode: failure state, code 21nn
// - Fault mode sets warning bit 13
// - First emergency node ID is kept
// - Warning mode sets bit 13 and flag, no failure
// - Fault/warn or own breakdown sets flag
// - Flag cleared by fault acknowledgment
// - Boot-up frame 1792+ID, one zero byte
// - NMT uses ID 0, cmd and node
// - Act if node matches or zero
// - Start command enters operational, enables PDO
// - Reset commands reinit, preop, new boot-up
// - SYNC with zero or one byte accepted
// - Sync event selectable SYNC or RxPDO
// - Sync forwards RxPDO, sends TxPDO
// - Stopped blocks SDO and PDO; preop PDO
`timescale 1ns/100ps
`include "sbn_defs.svh"
module sbn_node
#(
    // Millisecond tick length in clock cycles
    parameter int TICK_CYC = `SBN_TICK_CYC
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Configuration
    input wire logic i_is_master,
    input wire logic [6:0] i_node_id,
    input wire logic [10:0] i_sync_id_cfg,
    input wire logic [15:0] i_sync_period_ms,
    input wire logic i_sync_pdo_cfg,
    input wire logic [1:0] i_emcy_react,
    input wire logic i_sync_on_rpdo,
    // Application events
    input wire logic i_init_done,
    input wire logic i_fault,
    input wire logic [63:0] i_fault_data,
    input wire logic i_fault_ack,
    input wire logic i_self_breakdown,
    input wire logic [63:0] i_tpdo_app_data,
    // Received frame
    input wire logic i_rx_valid,
    input wire logic [10:0] i_rx_id,
    input wire logic [3:0] i_rx_dlc,
    input wire logic [63:0] i_rx_data,
    input wire logic i_rx_is_rpdo,
    // Frame transmitter
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic [10:0] o_tx_id,
    output logic [3:0] o_tx_dlc,
    output logic [63:0] o_tx_data,
    // Synchronous process data
    output logic o_sync_event,
    output logic [63:0] o_rpdo_app_data,
    output logic o_tpdo_send,
    output logic [63:0] o_tpdo_data,
    // Status
    output logic [2:0] o_nmt_state,
    output logic o_pdo_enable,
    output logic o_sdo_enable,
    output logic o_failure,
    output logic [15:0] o_error_type_code,
    output logic [15:0] o_warning_status,
    output logic o_bus_fault_flag
);

typedef struct packed
{
    sbn_pkg::sbn_nmt_e nmt;
    sbn_pkg::sbn_tx_e tx;
    logic boot_pend;
    logic emcy_pend;
    logic zero_pend;
    logic [63:0] emcy_data;
    logic [16:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic sync_pend;
    logic [63:0] rpdo_buf;
    logic [63:0] rpdo_out;
    logic sync_ev;
    logic tpdo_send;
    logic [63:0] tpdo_data;
    logic failure;
    logic [15:0] err_code;
    logic warn13;
    logic bus_flag;
    logic [10:0] tx_id;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
} sbn_state_s;

localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);

sbn_state_s st;
sbn_state_s next_st;

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers for asynchronous application levels
logic [1:0] fault_sy;
logic [1:0] ack_sy;
logic [1:0] brk_sy;
logic fault_q;
logic ack_q;

always_ff @(posedge i_clk_sys or posedge i_rst)
begin
    if (i_rst)
    begin
        fault_sy <= 2'h0;
        ack_sy <= 2'h0;
        brk_sy <= 2'h0;
        fault_q <= 1'b0;
        ack_q <= 1'b0;
    end
    else
    begin
        fault_sy <= {fault_sy[0], i_fault};
        ack_sy <= {ack_sy[0], i_fault_ack};
        brk_sy <= {brk_sy[0], i_self_breakdown};
        fault_q <= fault_sy[1];
        ack_q <= ack_sy[1];
    end
end

wire fault_rise = fault_sy[1] & ~fault_q;
wire ack_rise = ack_sy[1] & ~ack_q;

////////////////////////////////////////////////////////////////////////////
// Frame decode
logic [10:0] sync_id;
logic nmt_hit;
logic sync_hit;
logic emcy_hit;
logic [6:0] emcy_node;

always_comb
begin
    sync_id = (i_sync_id_cfg == 11'h000) ? `SBN_SYNC_ID_DEF : i_sync_id_cfg;
    nmt_hit = i_rx_valid && (i_rx_id == `SBN_NMT_ID) && !i_is_master
        && (i_rx_dlc == 4'h2)
        && ((i_rx_data[15:8] == {1'b0, i_node_id})
        || (i_rx_data[15:8] == 8'h00));
    // zero or one byte SYNC, shared identifier
    sync_hit = i_rx_valid && (i_rx_id == sync_id) && (i_rx_dlc <= 4'h1);
    emcy_node = 7'(i_rx_id - `SBN_EMCY_ID_BASE);
    emcy_hit = i_rx_valid && i_is_master && (i_rx_dlc == 4'h8)
        && (i_rx_id > `SBN_EMCY_ID_BASE) && (i_rx_id <= 11'h0BF);
end

////////////////////////////////////////////////////////////////////////////
// Next state
always_comb
begin
    next_st = st;
    next_st.sync_ev = 1'b0;
    next_st.tpdo_send = 1'b0;
    // Transmit arbiter first: requests raised below win a same-cycle clear
    case (st.tx)
        sbn_pkg::SBN_TX_IDLE:
        begin
            if (st.boot_pend)
            begin
                next_st.tx = sbn_pkg::SBN_TX_BOOT;
                next_st.tx_id = `SBN_BOOT_ID_BASE + {4'h0, i_node_id};
                next_st.tx_dlc = 4'h1;
                next_st.tx_data = 64'h0;
                next_st.boot_pend = 1'b0;
            end
            else if (st.emcy_pend || st.zero_pend)
            begin
                next_st.tx = sbn_pkg::SBN_TX_EMCY;
                next_st.tx_id = `SBN_EMCY_ID_BASE + {4'h0, i_node_id};
                next_st.tx_dlc = 4'h8;
                next_st.tx_data = st.emcy_pend ? st.emcy_data : 64'h0;
                if (st.emcy_pend)
                begin
                    next_st.emcy_pend = 1'b0;
                end
                else
                begin
                    next_st.zero_pend = 1'b0;
                end
            end
            else if (st.sync_pend)
            begin
                next_st.tx = sbn_pkg::SBN_TX_SYNC;
                next_st.tx_id = sync_id;
                next_st.tx_dlc = 4'h0;
                next_st.tx_data = 64'h0;
                next_st.sync_pend = 1'b0;
            end
        end
        sbn_pkg::SBN_TX_BOOT,
        sbn_pkg::SBN_TX_EMCY,
        sbn_pkg::SBN_TX_SYNC:
        begin
            if (i_tx_ready)
            begin
                next_st.tx = sbn_pkg::SBN_TX_IDLE;
            end
        end
        default: next_st.tx = sbn_pkg::SBN_TX_IDLE;
    endcase
    if (i_rx_valid && i_rx_is_rpdo)
    begin
        next_st.rpdo_buf = i_rx_data;
    end
    if (i_init_done)
    begin
        next_st.boot_pend = 1'b1;
    end
    if (nmt_hit)
    begin
        case (i_rx_data[7:0])
            `SBN_CS_START: next_st.nmt = sbn_pkg::SBN_ST_OPER;
            `SBN_CS_STOP: next_st.nmt = sbn_pkg::SBN_ST_STOP;
            `SBN_CS_PREOP: next_st.nmt = sbn_pkg::SBN_ST_PREOP;
            `SBN_CS_RST_NODE,
            `SBN_CS_RST_COMM:
            begin
                next_st.nmt = sbn_pkg::SBN_ST_PREOP;
                next_st.boot_pend = 1'b1;
            end
            default: next_st.nmt = st.nmt;
        endcase
    end
    // slave emergency requests; ack queues a zero frame
    if (!i_is_master && fault_rise)
    begin
        next_st.emcy_pend = 1'b1;
        next_st.emcy_data = i_fault_data;
    end
    if (!i_is_master && ack_rise)
    begin
        next_st.zero_pend = 1'b1;
    end
    if (st.tick_cnt == TICK_LAST)
    begin
        next_st.tick_cnt = 17'h00000;
    end
    else
    begin
        next_st.tick_cnt = st.tick_cnt + 17'h00001;
    end
    if (!i_is_master || !i_sync_pdo_cfg || i_sync_period_ms == 16'h0000)
    begin
        next_st.ms_cnt = 16'h0000;
    end
    else if (st.tick_cnt == TICK_LAST)
    begin
        if (st.ms_cnt + 16'h0001 >= i_sync_period_ms)
        begin
            next_st.ms_cnt = 16'h0000;
            next_st.sync_pend = 1'b1;
        end
        else
        begin
            next_st.ms_cnt = st.ms_cnt + 16'h0001;
        end
    end
    if (st.nmt == sbn_pkg::SBN_ST_OPER
        && ((i_sync_on_rpdo ? (i_rx_valid && i_rx_is_rpdo) : sync_hit)
        || (st.tx == sbn_pkg::SBN_TX_SYNC && i_tx_ready)))
    begin
        next_st.sync_ev = 1'b1;
        next_st.rpdo_out = (i_rx_valid && i_rx_is_rpdo) ? i_rx_data
            : st.rpdo_buf;
        next_st.tpdo_send = 1'b1;
        next_st.tpdo_data = i_tpdo_app_data;
    end
    if (emcy_hit && i_rx_data != 64'h0 && i_emcy_react != `SBN_REACT_IGNORE)
    begin
        next_st.warn13 = 1'b1;
        next_st.bus_flag = 1'b1;
        if (i_emcy_react == `SBN_REACT_FAULT)
        begin
            next_st.failure = 1'b1;
            if (!st.failure)
            begin
                next_st.err_code = {`SBN_ERR_HI, 1'b0, emcy_node};
            end
        end
    end
    if (i_is_master && ack_rise && !(emcy_hit && i_rx_data != 64'h0))
    begin
        next_st.bus_flag = 1'b0;
        next_st.failure = 1'b0;
        next_st.warn13 = 1'b0;
        next_st.err_code = `SBN_RST_ERR;
    end
    if (i_is_master && brk_sy[1])
    begin
        next_st.bus_flag = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// State register
always_ff @(posedge i_clk_sys or posedge i_rst)
begin
    if (i_rst)
    begin
        st <= '0;
        st.nmt <= sbn_pkg::SBN_ST_PREOP;
        st.tx <= sbn_pkg::SBN_TX_IDLE;
        st.err_code <= `SBN_RST_ERR;
    end
    else
    begin
        st <= next_st;
    end
end

////////////////////////////////////////////////////////////////////////////
// Outputs
always_comb
begin
    o_tx_valid = (st.tx != sbn_pkg::SBN_TX_IDLE);
    o_tx_id = st.tx_id;
    o_tx_dlc = st.tx_dlc;
    o_tx_data = st.tx_data;
    o_sync_event = st.sync_ev;
    o_rpdo_app_data = st.rpdo_out;
    o_tpdo_send = st.tpdo_send;
    o_tpdo_data = st.tpdo_data;
    o_nmt_state = st.nmt;
    o_pdo_enable = (st.nmt == sbn_pkg::SBN_ST_OPER);
    o_sdo_enable = (st.nmt != sbn_pkg::SBN_ST_STOP);
    o_failure = st.failure;
    o_error_type_code = st.err_code;
    o_warning_status = {2'h0, st.warn13, 13'h0000};
    o_bus_fault_flag = st.bus_flag;
end

////////////////////////////////////////////////////////////////////////////
// Checks
AST_SYNC_EMPTY: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    st.tx == sbn_pkg::SBN_TX_SYNC |-> o_tx_dlc == 4'h0)
    else $error("SYNC frame carries data");
AST_SYNC_DEF_ID: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    st.tx == sbn_pkg::SBN_TX_SYNC && i_sync_id_cfg == 11'h000
    |-> o_tx_id == 11'h080)
    else $error("SYNC default identifier wrong");
AST_SYNC_OFF: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_sync_period_ms == 16'h0000 |=> !st.sync_pend || $past(st.sync_pend))
    else $error("SYNC raised while disabled");
AST_BOOT_FRAME: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    st.tx == sbn_pkg::SBN_TX_BOOT
    |-> o_tx_dlc == 4'h1 && o_tx_data == 64'h0
    && o_tx_id == 11'h700 + {4'h0, i_node_id})
    else $error("Boot-up frame malformed");
AST_EMCY_LEN: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    st.tx == sbn_pkg::SBN_TX_EMCY |-> o_tx_dlc == 4'h8)
    else $error("Emergency frame length wrong");
AST_FAULT_CODE: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    emcy_hit && i_rx_data != 64'h0 && i_emcy_react == 2'h0 && !st.failure
    && !ack_rise |=> o_failure && o_error_type_code[15:8] == 8'h21)
    else $error("Fault shutdown not recorded");
AST_FIRST_KEPT: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    st.failure && !ack_rise |=> $stable(o_error_type_code))
    else $error("First failed node overwritten");
AST_WARN_ONLY: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    emcy_hit && i_rx_data != 64'h0 && i_emcy_react == 2'h1 && !st.failure
    |=> !o_failure && o_warning_status[13])
    else $error("Warning mode misbehaved");
AST_FLAG_SET: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    o_warning_status[13] |-> o_bus_fault_flag)
    else $error("Bus fault flag missing");
AST_PDO_GATE: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    o_tpdo_send |-> $past(st.nmt) == sbn_pkg::SBN_ST_OPER)
    else $error("PDO sent outside operational");
AST_START_CMD: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    nmt_hit && i_rx_data[7:0] == 8'h01 |=> o_pdo_enable)
    else $error("Start command not obeyed");
COV_SYNC_TX: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    st.tx == sbn_pkg::SBN_TX_SYNC && i_tx_ready);
COV_FAULT: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_failure));
COV_RESET_CMD: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    nmt_hit && i_rx_data[7:0] == 8'h82);
COV_SYNC_EV: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_sync_event);

endmodule

// *** verification/sbn_bus_model.sv ***
`timescale 1ns/100ps
module sbn_bus_model
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Frame handshake
    input wire logic i_tx_valid,
    output logic o_tx_ready
);
    ////////////////////////////////////////////////////////////////////////
    // only accepts frames
    // Random arbitration loss stands in for other bus traffic
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            o_tx_ready <= 1'b0;
        else
            o_tx_ready <= i_tx_valid && !o_tx_ready && ($urandom % 3 == 0);
    end
endmodule

// *** verification/sbn_node_tb.sv ***
`timescale 1ns/100ps
module sbn_node_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_is_master = 1'b0;
    logic i_sync_pdo_cfg = 1'b0;
    logic i_init_done = 1'b0;
    logic i_fault = 1'b0;
    logic i_fault_ack = 1'b0;
    logic i_self_breakdown = 1'b0;
    logic i_rx_valid = 1'b0;
    logic i_rx_is_rpdo = 1'b0;
    logic i_sync_on_rpdo = 1'b0;
    logic [15:0] i_sync_period_ms = 16'h0000;
    logic [1:0] i_emcy_react = 2'h0;
    logic [63:0] i_fault_data = 64'h0;
    logic [63:0] i_tpdo_app_data = 64'h0;
    logic [10:0] i_rx_id = 11'h000;
    logic [3:0] i_rx_dlc = 4'h0;
    logic [63:0] i_rx_data = 64'h0;
    logic i_tx_ready, o_tx_valid, o_sync_event, o_tpdo_send;
    logic o_pdo_enable, o_sdo_enable, o_failure, o_bus_fault_flag;
    logic [10:0] o_tx_id;
    logic [3:0] o_tx_dlc;
    logic [2:0] o_nmt_state;
    logic [63:0] o_tx_data, o_rpdo_app_data, o_tpdo_data, d1, d2;
    logic [15:0] o_error_type_code, o_warning_status;
    logic [78:0] exp_q[$];
    int n_errors = 0;
    int n_compared = 0;
    int n_sync = 0;
    logic [7:0] cs [9] = '{8'h01, 8'h01, 8'h02, 8'h80, 8'h01, 8'h81,
                           8'h01, 8'h82, 8'h01};
    logic [7:0] nd [9] = '{8'h07, 8'h05, 8'h00, 8'h05, 8'h00, 8'h05,
                           8'h05, 8'h00, 8'h00};
    logic [2:0] st [9] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h1, 3'h2,
                           3'h1, 3'h2};
    ////////////////////////////////////////////////////////////////////////
    // shared default sync id, tied
    // Short tick keeps the SYNC period within a brief run
    sbn_node #(.TICK_CYC(32'h000003E8)) dut_u
    (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_is_master(i_is_master),
        .i_node_id(7'h05), .i_sync_id_cfg(11'h000),
        .i_sync_period_ms(i_sync_period_ms), .i_sync_pdo_cfg(i_sync_pdo_cfg),
        .i_emcy_react(i_emcy_react), .i_sync_on_rpdo(i_sync_on_rpdo),
        .i_init_done(i_init_done), .i_fault(i_fault),
        .i_fault_data(i_fault_data), .i_fault_ack(i_fault_ack),
        .i_self_breakdown(i_self_breakdown),
        .i_tpdo_app_data(i_tpdo_app_data), .i_rx_valid(i_rx_valid),
        .i_rx_id(i_rx_id), .i_rx_dlc(i_rx_dlc), .i_rx_data(i_rx_data),
        .i_rx_is_rpdo(i_rx_is_rpdo), .o_tx_valid(o_tx_valid),
        .i_tx_ready(i_tx_ready), .o_tx_id(o_tx_id), .o_tx_dlc(o_tx_dlc),
        .o_tx_data(o_tx_data), .o_sync_event(o_sync_event),
        .o_rpdo_app_data(o_rpdo_app_data), .o_tpdo_send(o_tpdo_send),
        .o_tpdo_data(o_tpdo_data), .o_nmt_state(o_nmt_state),
        .o_pdo_enable(o_pdo_enable), .o_sdo_enable(o_sdo_enable),
        .o_failure(o_failure), .o_error_type_code(o_error_type_code),
        .o_warning_status(o_warning_status),
        .o_bus_fault_flag(o_bus_fault_flag)
    );
    sbn_bus_model bus_u
    (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready)
    );
    initial
    begin
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [78:0] seen, input logic [78:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic rx(input logic [10:0] id, input logic [3:0] dlc,
                      input logic [63:0] d, input logic rp);
        i_rx_valid <= 1'b1;
        i_rx_id <= id;
        i_rx_dlc <= dlc;
        i_rx_data <= d;
        i_rx_is_rpdo <= rp;
        tick(1);
        i_rx_valid <= 1'b0;
        tick(2);
    endtask
    // Bounded: a frame that never leaves ends the run
    task automatic drain(input int bound);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < bound)
        begin
            tick(1);
            k++;
        end
        if (exp_q.size() != 0)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Monitor: every accepted frame matches the oldest note
    always @(posedge i_clk_sys)
    begin
        if (o_sync_event === 1'b1 && o_tpdo_send === 1'b1)
            n_sync++;
        if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check({o_tx_id, o_tx_dlc, o_tx_data}, '1);
            else
                check({o_tx_id, o_tx_dlc, o_tx_data}, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(30200));
        tick(6);
        i_rst <= 1'b0;
        tick(1);
        check({o_nmt_state, o_sdo_enable, o_pdo_enable}, 5'h06);
        exp_q.push_back({11'h705, 4'h1, 64'h0});
        i_init_done <= 1'b1;
        tick(1);
        i_init_done <= 1'b0;
        drain(200);
        for (int i = 0; i < 9; i++)
        begin
            if (cs[i] > 8'h80)
                exp_q.push_back({11'h705, 4'h1, 64'h0});
            rx(11'h000, 4'h2, {48'h0, nd[i], cs[i]}, 1'b0);
            check({o_nmt_state, o_pdo_enable, o_sdo_enable},
                  {st[i], st[i] == 3'h2, st[i] != 3'h4});
            drain(200);
        end
        d1 = {$urandom, $urandom};
        d2 = ~d1;
        i_tpdo_app_data <= {$urandom, $urandom};
        rx(11'h185, 4'h8, d1, 1'b1);
        rx(11'h080, 4'h1, 64'hFF, 1'b0);
        check(o_rpdo_app_data, d1);
        check(o_tpdo_data, i_tpdo_app_data);
        rx(11'h185, 4'h8, d2, 1'b1);
        rx(11'h080, 4'h2, 64'h0, 1'b0);
        check(o_rpdo_app_data, d1);
        rx(11'h080, 4'h0, 64'h0, 1'b0);
        check(o_rpdo_app_data, d2);
        i_sync_on_rpdo <= 1'b1;
        rx(11'h080, 4'h0, 64'h0, 1'b0);
        check(o_rpdo_app_data, d2);
        rx(11'h185, 4'h8, d1, 1'b1);
        check(o_rpdo_app_data, d1);
        check(n_sync, 3);
        i_sync_on_rpdo <= 1'b0;
        i_fault_data <= {$urandom, $urandom} | 64'h1;
        i_fault <= 1'b1;
        tick(1);
        exp_q.push_back({11'h085, 4'h8, i_fault_data});
        drain(300);
        exp_q.push_back({11'h085, 4'h8, 64'h0});
        i_fault_ack <= 1'b1;
        drain(300);
        i_fault <= 1'b0;
        i_fault_ack <= 1'b0;
        // Master role is static, so it needs a fresh reset
        i_rst <= 1'b1;
        i_is_master <= 1'b1;
        i_sync_pdo_cfg <= 1'b1;
        i_sync_period_ms <= 16'h0002;
        tick(2);
        i_rst <= 1'b0;
        exp_q.push_back({11'h080, 4'h0, 64'h0});
        exp_q.push_back({11'h080, 4'h0, 64'h0});
        for (int r = 0; r < 3; r++)
        begin
            i_emcy_react <= r[1:0];
            rx(11'h083, 4'h8, 64'h0, 1'b0);
            check({o_failure, o_warning_status}, 17'h0);
            rx(11'h083, 4'h8, {$urandom, $urandom} | 64'h1, 1'b0);
            rx(11'h084, 4'h8, 64'h10, 1'b0);
            check({o_failure, o_error_type_code, o_warning_status,
                   o_bus_fault_flag}, {r == 0, r == 0 ? 16'h2103 : 16'h0,
                   r < 2 ? 16'h2000 : 16'h0, r < 2});
            i_fault_ack <= 1'b1;
            tick(8);
            i_fault_ack <= 1'b0;
            tick(2);
            check({o_failure, o_error_type_code, o_warning_status,
                   o_bus_fault_flag}, 34'h0);
        end
        i_self_breakdown <= 1'b1;
        tick(8);
        check(o_bus_fault_flag, 1'b1);
        i_self_breakdown <= 1'b0;
        i_fault_ack <= 1'b1;
        tick(8);
        check(o_bus_fault_flag, 1'b0);
        drain(5000);
        // period zero: any SYNC from here on is an unexpected frame
        i_sync_period_ms <= 16'h0000;
        tick(3000);
        report_and_stop();
    end
endmodule
